/* File: shared/oedc_pkg.sv */
// constants and types for the output extension delay control block
// assumes one 100 MHz clock and a synchronous active-high reset
package oedc_pkg;
    // ************************************************************
    // timing
    // ************************************************************
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned TICK_MS = 100;
    // cycles per 100 ms tick, exact at 100 MHz
    localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned TICK_W = 24;
    // delays counted in 100 ms ticks, 90 s is 900 ticks
    localparam int unsigned DLY_W = 10;
    // fast blink about 2.5 Hz, slow about 1 Hz (half periods in ticks)
    localparam logic [3:0] FAST_HALF = 4'h2;
    localparam logic [3:0] SLOW_HALF = 4'h5;
    localparam int unsigned SEL_W = 4;
    localparam logic [SEL_W-1:0] SEL_ZERO = 4'h0;
    localparam logic [DLY_W-1:0] DLY_ZERO = 10'h000;
    localparam logic [DLY_W-1:0] DLY_ONE = 10'h001;
    // preset delays in 100 ms ticks, one per selector code
    localparam logic [DLY_W-1:0] DLY_0MS = 10'h000;
    localparam logic [DLY_W-1:0] DLY_100MS = 10'h001;
    localparam logic [DLY_W-1:0] DLY_200MS = 10'h002;
    localparam logic [DLY_W-1:0] DLY_500MS = 10'h005;
    localparam logic [DLY_W-1:0] DLY_1S = 10'h00a;
    localparam logic [DLY_W-1:0] DLY_1S5 = 10'h00f;
    localparam logic [DLY_W-1:0] DLY_2S = 10'h014;
    localparam logic [DLY_W-1:0] DLY_2S5 = 10'h019;
    localparam logic [DLY_W-1:0] DLY_5S = 10'h032;
    localparam logic [DLY_W-1:0] DLY_10S = 10'h064;
    localparam logic [DLY_W-1:0] DLY_20S = 10'h0c8;
    localparam logic [DLY_W-1:0] DLY_30S = 10'h12c;
    localparam logic [DLY_W-1:0] DLY_45S = 10'h1c2;
    localparam logic [DLY_W-1:0] DLY_60S = 10'h258;
    localparam logic [DLY_W-1:0] DLY_75S = 10'h2ee;
    localparam logic [DLY_W-1:0] DLY_90S = 10'h384;
    localparam logic [TICK_W-1:0] TICK_ZERO = 24'h000000;
    localparam logic [TICK_W-1:0] TICK_ONE = 24'h000001;
    localparam logic [3:0] BLINK_ZERO = 4'h0;
    localparam logic [3:0] BLINK_ONE = 4'h1;

    // ************************************************************
    // control states
    // ************************************************************
    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_ON_DLY = 3'b001,
        ST_ON = 3'b010,
        ST_OFF_DLY = 3'b011,
        ST_LOCK = 3'b100
    } oedc_state_t;
endpackage

/* File: core/oedc_delay_table.sv */
// selector code to delay (in 100 ms ticks) lookup
// assumes codes already synchronised in the caller's clock domain
`timescale 1ns/10ps
`default_nettype none
module oedc_delay_table (
    input wire logic [3:0] code,
    output logic [9:0] ticks
);
    // ************************************************************
    // lookup
    // ************************************************************
    // sixteen presets, 0 s up to 90 s
    always_comb begin
        case (code)
            4'h0: ticks = oedc_pkg::DLY_0MS;
            4'h1: ticks = oedc_pkg::DLY_100MS;
            4'h2: ticks = oedc_pkg::DLY_200MS;
            4'h3: ticks = oedc_pkg::DLY_500MS;
            4'h4: ticks = oedc_pkg::DLY_1S;
            4'h5: ticks = oedc_pkg::DLY_1S5;
            4'h6: ticks = oedc_pkg::DLY_2S;
            4'h7: ticks = oedc_pkg::DLY_2S5;
            4'h8: ticks = oedc_pkg::DLY_5S;
            4'h9: ticks = oedc_pkg::DLY_10S;
            4'ha: ticks = oedc_pkg::DLY_20S;
            4'hb: ticks = oedc_pkg::DLY_30S;
            4'hc: ticks = oedc_pkg::DLY_45S;
            4'hd: ticks = oedc_pkg::DLY_60S;
            4'he: ticks = oedc_pkg::DLY_75S;
            4'hf: ticks = oedc_pkg::DLY_90S;
            default: ticks = oedc_pkg::DLY_ZERO;
        endcase
    end
endmodule // oedc_delay_table
`default_nettype wire

/* File: core/oedc_top.sv */
// control of an output extension unit: delayed relay outputs and LEDs
// assumes pins arrive asynchronously; one 100 MHz clock, sync reset
`timescale 1ns/10ps
`default_nettype none
module oedc_top (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic chain_in_terminal,
    input wire logic chain_in_valid,
    input wire logic remote_comm_error,
    input wire logic local_comm_error,
    input wire logic [3:0] rotary_sel_1,
    input wire logic [3:0] rotary_sel_2,
    input wire logic [3:0] rotary_sel_3,
    input wire logic [3:0] rotary_sel_4,
    input wire logic feedback_input_terminal,
    input wire logic contactor_feedback_monitor_en,
    input wire logic self_test_fail,
    output logic [2:0] safety_switching_output,
    output logic chain_out_terminal,
    output logic link_indicator,
    output logic feedback_indicator,
    output logic output_indicator,
    output logic fault_indicator,
    output logic lockout
);
    // ************************************************************
    // input synchronisers
    // ************************************************************
    localparam int unsigned NSYNC = 22;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync1_reg;
    logic [NSYNC-1:0] sync2_reg;
    assign raw_in = {chain_in_terminal, chain_in_valid, remote_comm_error,
                     local_comm_error, rotary_sel_1, rotary_sel_2,
                     rotary_sel_3, rotary_sel_4, feedback_input_terminal,
                     contactor_feedback_monitor_en};
    // two flops per pin; first stage read only by the second
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi++) begin : g_sync
            always_ff @(posedge ref_clk) begin
                if (reset) begin
                    sync1_reg[gi] <= 1'b0;
                    sync2_reg[gi] <= 1'b0;
                end else begin
                    sync1_reg[gi] <= raw_in[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate
    logic s_enable, s_valid, s_rerr, s_lerr, s_fb, s_fb_en;
    logic [3:0] s_sel1, s_sel2, s_sel3, s_sel4;
    assign {s_enable, s_valid, s_rerr, s_lerr, s_sel1, s_sel2, s_sel3,
            s_sel4, s_fb, s_fb_en} = sync2_reg;
    // self-test result is already internal logic on this clock
    logic s_stf;
    assign s_stf = self_test_fail;

    // ************************************************************
    // selector checking and decode
    // ************************************************************
    logic on_ok, off_ok, sel_ok;
    logic [9:0] on_ticks, off_ticks;
    assign on_ok = (s_sel1 == s_sel3);
    assign off_ok = (s_sel2 == s_sel4);
    assign sel_ok = on_ok && off_ok;
    // separate decoders so one setting never disturbs the other
    oedc_delay_table u_on_tab (
        .code(s_sel1),
        .ticks(on_ticks)
    );
    oedc_delay_table u_off_tab (
        .code(s_sel2),
        .ticks(off_ticks)
    );

    // snapshot of the settings in use; any change while running locks
    logic [15:0] sel_snap_reg;
    logic sel_changed;
    logic running;
    assign sel_changed = (sel_snap_reg != {s_sel1, s_sel2, s_sel3, s_sel4});

    // ************************************************************
    // 100 ms tick
    // ************************************************************
    logic [oedc_pkg::TICK_W-1:0] tick_cnt_reg;
    logic tick;
    assign tick = (tick_cnt_reg ==
                   oedc_pkg::TICK_W'(oedc_pkg::TICK_CYCLES - 1));
    // single free-running divider sets every delay's resolution
    always_ff @(posedge ref_clk) begin
        if (reset || tick) begin
            tick_cnt_reg <= oedc_pkg::TICK_ZERO;
        end else begin
            tick_cnt_reg <= tick_cnt_reg + oedc_pkg::TICK_ONE;
        end
    end

    // ************************************************************
    // delay state machine
    // ************************************************************
    oedc_pkg::oedc_state_t state_reg;
    logic [9:0] dly_reg;
    logic go;
    // enable counts only with a valid link from the primary
    assign go = s_enable && s_valid;
    assign running = (state_reg != oedc_pkg::ST_OFF) &&
                     (state_reg != oedc_pkg::ST_LOCK);

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            state_reg <= oedc_pkg::ST_OFF;
            dly_reg <= oedc_pkg::DLY_ZERO;
        end else begin
            case (state_reg)
                oedc_pkg::ST_OFF: begin
                    // mismatched pair holds outputs off
                    if (go && sel_ok && !s_stf) begin
                        state_reg <= oedc_pkg::ST_ON_DLY;
                        dly_reg <= on_ticks;
                    end
                end
                oedc_pkg::ST_ON_DLY: begin
                    if (sel_changed || !sel_ok) begin
                        state_reg <= oedc_pkg::ST_LOCK;
                    end else if (!go) begin
                        state_reg <= oedc_pkg::ST_OFF;
                    end else if (dly_reg == oedc_pkg::DLY_ZERO) begin
                        state_reg <= oedc_pkg::ST_ON;
                    end else if (tick) begin
                        dly_reg <= dly_reg - oedc_pkg::DLY_ONE;
                    end
                end
                oedc_pkg::ST_ON: begin
                    if (sel_changed || !sel_ok) begin
                        state_reg <= oedc_pkg::ST_LOCK;
                    end else if (!go) begin
                        state_reg <= oedc_pkg::ST_OFF_DLY;
                        dly_reg <= off_ticks;
                    end
                end
                oedc_pkg::ST_OFF_DLY: begin
                    if (sel_changed || !sel_ok) begin
                        state_reg <= oedc_pkg::ST_LOCK;
                    end else if (go) begin
                        state_reg <= oedc_pkg::ST_ON; // enable came back
                    end else if (dly_reg == oedc_pkg::DLY_ZERO) begin
                        state_reg <= oedc_pkg::ST_OFF;
                    end else if (tick) begin
                        dly_reg <= dly_reg - oedc_pkg::DLY_ONE;
                    end
                end
                oedc_pkg::ST_LOCK: begin
                    // latched until reset, i.e. power cycle
                    state_reg <= oedc_pkg::ST_LOCK;
                end
                default: begin
                    state_reg <= oedc_pkg::ST_LOCK;
                end
            endcase
        end
    end

    // settings are captured while idle, frozen while running
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            sel_snap_reg <= 16'h0000;
        end else if (!running) begin
            sel_snap_reg <= {s_sel1, s_sel2, s_sel3, s_sel4};
        end
    end

    // ************************************************************
    // blink generators
    // ************************************************************
    logic [3:0] fast_cnt_reg, slow_cnt_reg;
    logic fast_reg, slow_reg;
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fast_cnt_reg <= oedc_pkg::BLINK_ZERO;
            fast_reg <= 1'b0;
        end else if (tick) begin
            if (fast_cnt_reg ==
                oedc_pkg::FAST_HALF - oedc_pkg::BLINK_ONE) begin
                fast_cnt_reg <= oedc_pkg::BLINK_ZERO;
                fast_reg <= !fast_reg;
            end else begin
                fast_cnt_reg <= fast_cnt_reg + oedc_pkg::BLINK_ONE;
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            slow_cnt_reg <= oedc_pkg::BLINK_ZERO;
            slow_reg <= 1'b0;
        end else if (tick) begin
            if (slow_cnt_reg ==
                oedc_pkg::SLOW_HALF - oedc_pkg::BLINK_ONE) begin
                slow_cnt_reg <= oedc_pkg::BLINK_ZERO;
                slow_reg <= !slow_reg;
            end else begin
                slow_cnt_reg <= slow_cnt_reg + oedc_pkg::BLINK_ONE;
            end
        end
    end

    // ************************************************************
    // feedback monitoring
    // ************************************************************
    // contactors closed (input high) while relays are on is a fault; not checked with relays off
    logic fb_err_reg;
    logic outs_on;
    assign outs_on = (state_reg == oedc_pkg::ST_ON) ||
                     (state_reg == oedc_pkg::ST_OFF_DLY);
    // simple static check; sticky until reset since it is a fault
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fb_err_reg <= 1'b0;
        end else if (s_fb_en && (outs_on == s_fb) && outs_on) begin
            fb_err_reg <= 1'b1;
        end
    end

    // ************************************************************
    // outputs, all from flops
    // ************************************************************
    logic counting;
    assign counting = (state_reg == oedc_pkg::ST_ON_DLY) ||
                      (state_reg == oedc_pkg::ST_OFF_DLY);
    logic local_fault;
    assign local_fault = s_lerr || !sel_ok ||
                         (state_reg == oedc_pkg::ST_LOCK);

    // relays and chain pass-through
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            safety_switching_output <= 3'h0;
            chain_out_terminal <= 1'b0;
            output_indicator <= 1'b0;
            lockout <= 1'b0;
        end else begin
            safety_switching_output <= {3{outs_on && !fb_err_reg}};
            chain_out_terminal <= s_enable;
            output_indicator <= outs_on && !fb_err_reg;
            lockout <= (state_reg == oedc_pkg::ST_LOCK);
        end
    end

    // link indicator: errors first, then countdown, then link state
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            link_indicator <= 1'b0;
        end else if (s_rerr) begin
            link_indicator <= fast_reg;
        end else if (s_lerr) begin
            link_indicator <= slow_reg;
        end else if (counting) begin
            link_indicator <= fast_reg;
        end else begin
            link_indicator <= s_valid;
        end
    end

    // fault indicator
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fault_indicator <= 1'b1;
        end else if (s_rerr) begin
            fault_indicator <= fast_reg;
        end else if (local_fault) begin
            fault_indicator <= slow_reg;
        end else if (s_stf || !outs_on || fb_err_reg) begin
            fault_indicator <= 1'b1;
        end else begin
            fault_indicator <= 1'b0;
        end
    end

    // feedback monitor indicator
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            feedback_indicator <= 1'b0;
        end else if (!s_fb_en) begin
            feedback_indicator <= 1'b0;
        end else if (fb_err_reg) begin
            feedback_indicator <= slow_reg;
        end else begin
            feedback_indicator <= 1'b1;
        end
    end
endmodule // oedc_top
`default_nettype wire

/* File: test/oedc_primary_model.sv */
// upstream primary unit model: drives chain enable and link valid
// assumes the bench commands it on ref_clk, one extension on the loop
`timescale 1ns/10ps
`default_nettype none
module oedc_primary_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic enable_cmd,
    input wire logic link_cmd,
    output logic chain_in_terminal,
    output logic chain_in_valid
);
    // ****************
    // loop drive
    // ****************
    // enable only with a live link, one unit here, well inside three
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            chain_in_terminal <= 1'b0;
            chain_in_valid <= 1'b0;
        end else begin
            chain_in_terminal <= enable_cmd & link_cmd;
            chain_in_valid <= link_cmd;
        end
    end
endmodule // oedc_primary_model
`default_nettype wire

/* File: test/oedc_top_chk.sv */
// port assertions for the delay control block
// assumes bind onto oedc_top, one clock, sync active-high reset
`timescale 1ns/10ps
`default_nettype none
module oedc_top_chk (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic chain_in_terminal,
    input wire logic chain_in_valid,
    input wire logic remote_comm_error,
    input wire logic local_comm_error,
    input wire logic [3:0] rotary_sel_1,
    input wire logic [3:0] rotary_sel_2,
    input wire logic [3:0] rotary_sel_3,
    input wire logic [3:0] rotary_sel_4,
    input wire logic feedback_input_terminal,
    input wire logic contactor_feedback_monitor_en,
    input wire logic self_test_fail,
    input wire logic [2:0] safety_switching_output,
    input wire logic chain_out_terminal,
    input wire logic link_indicator,
    input wire logic feedback_indicator,
    input wire logic output_indicator,
    input wire logic fault_indicator,
    input wire logic lockout
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);
    // ****************
    // properties
    // ****************
    // windows cover the two-flop sync plus state and output registers
    property p_out_equal;
        output_indicator == safety_switching_output[0] &&
        (safety_switching_output == 3'h0 || safety_switching_output == 3'h7);
    endproperty
    a_out_equal: assert property (p_out_equal)
        else $error("relay drives and output led disagree");
    property p_lock_off;
        lockout [*2] |-> safety_switching_output == 3'h0;
    endproperty
    a_lock_off: assert property (p_lock_off)
        else $error("outputs on during lockout");
    property p_lock_sticky;
        lockout |=> lockout;
    endproperty
    a_lock_sticky: assert property (p_lock_sticky)
        else $error("lockout left without reset");
    property p_lock_entry;
        output_indicator && !$stable(rotary_sel_1) |-> ##[1:6] lockout;
    endproperty
    a_lock_entry: assert property (p_lock_entry)
        else $error("selector change while on gave no lockout");
    property p_mismatch_off;
        (rotary_sel_1 != rotary_sel_3) [*6]
        |-> safety_switching_output == 3'h0;
    endproperty
    a_mismatch_off: assert property (p_mismatch_off)
        else $error("outputs on with on-delay pair mismatched");
    property p_link_dark;
        (!chain_in_valid && !remote_comm_error && !local_comm_error) [*5]
        |-> !link_indicator;
    endproperty
    a_link_dark: assert property (p_link_dark)
        else $error("link led lit without valid link");
    property p_chain_out;
        $stable(chain_in_terminal) [*5]
        |-> chain_out_terminal == chain_in_terminal;
    endproperty
    a_chain_out: assert property (p_chain_out)
        else $error("chain output does not follow chain input");
    property p_no_start;
        (!chain_in_terminal) [*8] |-> !$rose(output_indicator);
    endproperty
    a_no_start: assert property (p_no_start)
        else $error("outputs rose without chain enable");
    property p_fb_dark;
        (!contactor_feedback_monitor_en) [*4] |-> !feedback_indicator;
    endproperty
    a_fb_dark: assert property (p_fb_dark)
        else $error("feedback led lit with monitoring off");
    c_on: cover property (output_indicator);
    c_lock: cover property (lockout);
    c_off: cover property ($fell(output_indicator));
endmodule // oedc_top_chk
`default_nettype wire

/* File: test/test_output_extension_delay_control.sv */
// self-checking bench for the delay control block
// assumes only zero or short windows, the 100 ms tick never elapses
`timescale 1ns/10ps
`default_nettype none
module test_output_extension_delay_control;
    logic ref_clk, reset, enable_cmd, link_cmd, chain_in_terminal;
    logic chain_in_valid, remote_comm_error, local_comm_error;
    logic [3:0] rotary_sel_1, rotary_sel_2, rotary_sel_3, rotary_sel_4;
    logic feedback_input_terminal, contactor_feedback_monitor_en;
    logic self_test_fail, chain_out_terminal, link_indicator;
    logic feedback_indicator, output_indicator, fault_indicator, lockout;
    logic [2:0] safety_switching_output;
    logic [8:0] stat;
    int mismatches, samples_checked, cycles;
    // status word: relays, out led, fault, link, lockout, chain out, fb led
    assign stat = {safety_switching_output, output_indicator, fault_indicator,
        link_indicator, lockout, chain_out_terminal, feedback_indicator};
    oedc_primary_model i_primary (.ref_clk(ref_clk), .reset(reset),
        .enable_cmd(enable_cmd), .link_cmd(link_cmd),
        .chain_in_terminal(chain_in_terminal),
        .chain_in_valid(chain_in_valid));
    oedc_top i_dut (.ref_clk(ref_clk), .reset(reset),
        .chain_in_terminal(chain_in_terminal), .chain_in_valid(chain_in_valid),
        .remote_comm_error(remote_comm_error),
        .local_comm_error(local_comm_error), .rotary_sel_1(rotary_sel_1),
        .rotary_sel_2(rotary_sel_2), .rotary_sel_3(rotary_sel_3),
        .rotary_sel_4(rotary_sel_4),
        .feedback_input_terminal(feedback_input_terminal),
        .contactor_feedback_monitor_en(contactor_feedback_monitor_en),
        .self_test_fail(self_test_fail),
        .safety_switching_output(safety_switching_output),
        .chain_out_terminal(chain_out_terminal),
        .link_indicator(link_indicator),
        .feedback_indicator(feedback_indicator),
        .output_indicator(output_indicator),
        .fault_indicator(fault_indicator), .lockout(lockout));
    // ****************
    // clock and watchdog
    // ****************
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // whole run is about 1500 cycles, so 20000 means a hang
    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            mismatches++;
            finish_test();
        end
    end
    // ****************
    // shared tasks
    // ****************
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    // selectors packed as {1, 2, 3, 4}
    task automatic drive(input logic en, input logic [15:0] sel);
        @(posedge ref_clk);
        enable_cmd <= en;
        {rotary_sel_1, rotary_sel_2, rotary_sel_3, rotary_sel_4} <= sel;
    endtask
    task automatic do_reset;
        @(posedge ref_clk);
        reset <= 1'b1;
        enable_cmd <= 1'b0;
        self_test_fail <= 1'b0;
        tick(10);
        check(stat, 9'h010);
        @(posedge ref_clk);
        reset <= 1'b0;
    endtask
    task automatic finish_test;
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // ****************
    // scenarios
    // ****************
    task automatic t_on_off;
        drive(1'b1, 16'h0000);
        tick(12);
        check(stat, 9'h1ea);
        drive(1'b0, 16'h0000);
        tick(12);
        check(stat, 9'h018);
        // failed self-test must block a start and keep the fault led lit
        @(posedge ref_clk);
        self_test_fail <= 1'b1;
        drive(1'b1, 16'h0000);
        tick(12);
        check(stat & 9'h1f0, 9'h010);
        do_reset();
        $display("on off done");
    endtask
    // every code on each pair, the other pair held at zero delay
    task automatic t_codes;
        for (int c = 0; c < 16; c++) begin
            drive(1'b1, {c[3:0], 4'h0, c[3:0], 4'h0});
            tick(20);
            check(stat & 9'h1e4, (c == 0) ? 9'h1e0 : 9'h000);
            drive(1'b0, {c[3:0], 4'h0, c[3:0], 4'h0});
            tick(12);
            drive(1'b1, {4'h0, c[3:0], 4'h0, c[3:0]});
            tick(12);
            check(stat & 9'h1e4, 9'h1e0);
            drive(1'b0, {4'h0, c[3:0], 4'h0, c[3:0]});
            tick(20);
            check(stat & 9'h1e4, (c == 0) ? 9'h000 : 9'h1e0);
            do_reset();
        end
        $display("codes done");
    endtask
    task automatic t_mismatch;
        drive(1'b1, 16'h0020);
        tick(12);
        check(stat & 9'h1e4, 9'h000);
        drive(1'b1, 16'h0005);
        tick(12);
        check(stat & 9'h1e4, 9'h000);
        do_reset();
        $display("mismatch done");
    endtask
    task automatic t_lockout;
        drive(1'b1, 16'h0000);
        tick(12);
        drive(1'b1, 16'h1000);
        tick(10);
        check(stat & 9'h1e4, 9'h004);
        drive(1'b0, 16'h0000);
        tick(12);
        check(stat & 9'h1e4, 9'h004);
        do_reset();
        $display("lockout done");
    endtask
    task automatic t_link_fb;
        @(posedge ref_clk);
        link_cmd <= 1'b0;
        tick(8);
        check(stat & 9'h00a, 9'h000);
        @(posedge ref_clk);
        link_cmd <= 1'b1;
        contactor_feedback_monitor_en <= 1'b1;
        drive(1'b1, 16'h0000);
        tick(12);
        check(stat, 9'h1eb);
        @(posedge ref_clk);
        feedback_input_terminal <= 1'b1;
        tick(12);
        check(stat & 9'h1e0, 9'h000);
        @(posedge ref_clk);
        contactor_feedback_monitor_en <= 1'b0;
        feedback_input_terminal <= 1'b0;
        do_reset();
        $display("link and feedback done");
    endtask
    // comm errors make both leds blink; blink starts in dark phase
    task automatic t_comm;
        @(posedge ref_clk);
        remote_comm_error <= 1'b1;
        tick(6);
        check(stat & 9'h018, 9'h000);
        @(posedge ref_clk);
        remote_comm_error <= 1'b0;
        local_comm_error <= 1'b1;
        tick(6);
        check(stat & 9'h018, 9'h000);
        @(posedge ref_clk);
        local_comm_error <= 1'b0;
        tick(6);
        check(stat & 9'h018, 9'h018);
        $display("comm errors done");
    endtask
    initial begin
        reset = 1'b1;
        enable_cmd = 1'b0;
        link_cmd = 1'b1;
        remote_comm_error = 1'b0;
        local_comm_error = 1'b0;
        {rotary_sel_1, rotary_sel_2, rotary_sel_3, rotary_sel_4} = 16'h0000;
        feedback_input_terminal = 1'b0;
        contactor_feedback_monitor_en = 1'b0;
        self_test_fail = 1'b0;
        mismatches = 0;
        samples_checked = 0;
        do_reset();
        t_on_off();
        t_codes();
        t_mismatch();
        t_lockout();
        t_link_fb();
        t_comm();
        finish_test();
    end
endmodule // test_output_extension_delay_control
bind oedc_top oedc_top_chk i_chk (.ref_clk(ref_clk), .reset(reset),
    .chain_in_terminal(chain_in_terminal), .chain_in_valid(chain_in_valid),
    .remote_comm_error(remote_comm_error), .local_comm_error(local_comm_error),
    .rotary_sel_1(rotary_sel_1), .rotary_sel_2(rotary_sel_2),
    .rotary_sel_3(rotary_sel_3), .rotary_sel_4(rotary_sel_4),
    .feedback_input_terminal(feedback_input_terminal),
    .contactor_feedback_monitor_en(contactor_feedback_monitor_en),
    .self_test_fail(self_test_fail),
    .safety_switching_output(safety_switching_output),
    .chain_out_terminal(chain_out_terminal), .link_indicator(link_indicator),
    .feedback_indicator(feedback_indicator),
    .output_indicator(output_indicator), .fault_indicator(fault_indicator),
    .lockout(lockout));
`default_nettype wire
